// File: verilog/lsc_ctrl.sv
// lsc_ctrl: configuration, event gating and oscillator calibration of a
// lightning detector, with its register map on an AXI4-Lite slave.
// assumes event inputs come from detection logic on mclk; oscillator
// pins are asynchronous and are synchronised inside the meter.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module lsc_ctrl #(
   parameter longint WIN_FAST    = lsc_pkg::WIN_FAST_CYC,
   parameter longint WIN_SLOW    = lsc_pkg::WIN_SLOW_CYC,
   parameter longint STRIKE_WIN  = lsc_pkg::STRIKE_WIN_CYC
) (
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // detection events
   input  wire logic [2:0]  noise_meas,
   input  wire logic        disturber_evt,
   input  wire logic        strike_evt,
   // oscillator pins
   input  wire logic        antenna_lc_osc,
   input  wire logic        timer_rc_osc,
   input  wire logic        system_rc_osc,
   // controls to the analog side
   output logic             powered_down,
   output logic [4:0]       front_end_amplifier,
   output logic [3:0]       watchdog_threshold,
   output logic [3:0]       spike_rejection_level,
   output logic [3:0]       antenna_tune_cap,
   output logic [3:0]       timer_rc_trim,
   output logic [3:0]       system_rc_trim,
   output logic             irq
);
   import lsc_pkg::*;

   localparam int WIN_W = 24;
   localparam int CNT_W = 16;
   localparam int SW_W  = 40;

   if (WIN_FAST < 2 || WIN_SLOW < 2 ||
       WIN_SLOW >= (64'd1 << WIN_W)) begin : g_bad_win
      $error("lsc_ctrl: window lengths out of range");
   end
   if (STRIKE_WIN < 2 || STRIKE_WIN >= (64'd1 << SW_W)) begin : g_bad_sw
      $error("lsc_ctrl: strike window out of range");
   end

   localparam logic [CNT_W-1:0] TGT_ANT =
      CNT_W'(ANT_HZ * WIN_FAST / CLK_HZ);
   localparam logic [CNT_W-1:0] TGT_TMR =
      CNT_W'(TMR_HZ * WIN_FAST / CLK_HZ);
   localparam logic [CNT_W-1:0] TGT_SYS =
      CNT_W'(SYS_HZ * WIN_SLOW / CLK_HZ);

   // strikes needed before a lightning interrupt
   function automatic logic [4:0] min_strikes(input logic [1:0] sel);
      case (sel)
         2'h0:    min_strikes = 5'd1;
         2'h1:    min_strikes = 5'd5;
         2'h2:    min_strikes = 5'd9;
         default: min_strikes = 5'd16;
      endcase
   endfunction : min_strikes

   // whether the word index of a byte address is a map entry
   function automatic logic map_hit(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      map_hit = (idx <= 6'(IDX_LAST_MAP)) || idx == 6'(IDX_CAL_STAT) ||
                idx == 6'(IDX_TRIM);
   endfunction : map_hit

   logic [7:0]       map_ff [0:NUM_MAP-1];
   logic [7:0]       aw_addr_ff;
   logic             aw_have_ff;
   logic [31:0]      w_data_ff;
   logic             w_strb0_ff;
   logic             w_have_ff;
   logic             bvalid_ff;
   logic [1:0]       bresp_ff;
   logic             rvalid_ff;
   logic [31:0]      rdata_ff;
   logic [1:0]       rresp_ff;
   logic [3:0]       cause_ff;
   logic             noise_hi_ff;
   logic [4:0]       strike_cnt_ff;
   logic [SW_W-1:0]  strike_tmr_ff;
   lsc_cal_t         cal_st_ff;
   logic [1:0]       bit_ff;
   logic             meas_wait_ff;
   logic             ant_done_ff;
   logic             rc_done_ff;
   logic [3:0]       tmr_trim_ff;
   logic [3:0]       sys_trim_ff;
   logic             meas_start_ff;

   logic             wr_fire;
   logic [3:0]       wr_idx;
   logic             rd_fire;
   logic [3:0]       rd_idx;
   logic             pd;
   logic             ant_go;
   logic             rc_go;
   logic             noise_hi;
   logic             strike_ok;
   logic [3:0]       cause_set;
   logic             cause_clr;
   logic             osc_sel_pin;
   logic [WIN_W-1:0] meas_win;
   logic [CNT_W-1:0] meas_cnt;
   logic             meas_done;
   logic [3:0]       trial;
   logic             keep_bit;
   logic [3:0]       cap_wr_val;
   logic             cap_wr;

   assign pd     = map_ff[IDX_PWR_FE][POS_PWR_DOWN];
   assign wr_idx = aw_addr_ff[5:2];
   assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
   assign rd_idx = s_axi_araddr[5:2];
   assign rd_fire = s_axi_arvalid && !rvalid_ff;

   // handshake outputs
   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready  = !w_have_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // write channel capture, either order
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_addr_ff <= 8'h00;
         aw_have_ff <= 1'b0;
         w_data_ff  <= 32'h0;
         w_strb0_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_ff <= s_axi_awaddr;
            aw_have_ff <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_ff  <= s_axi_wdata;
            w_strb0_ff <= s_axi_wstrb[0];
            w_have_ff  <= 1'b1;
         end
         if (wr_fire) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= map_hit(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_MAP; i++)
            map_ff[i] <= RST_MAP[i];
      end else if (ce) begin
         if (wr_fire && w_strb0_ff && wr_idx <= IDX_LAST_MAP)
            map_ff[wr_idx] <= w_data_ff[7:0];
         // calibration result lands in tune field
         if (cap_wr)
            map_ff[IDX_TUNE][POS_CAP_LSB +: 4] <= cap_wr_val;
      end
   end

   assign ant_go = wr_fire && w_strb0_ff && wr_idx == IDX_TUNE &&
                   w_data_ff[POS_ANT_START];
   assign rc_go  = wr_fire && w_strb0_ff && wr_idx == IDX_TUNE &&
                   w_data_ff[POS_RC_START];

   // read path; status read clears the cause
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= map_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_ff  <= 32'h0;
            if (map_hit(s_axi_araddr)) begin
               if (rd_idx == IDX_INT_CAUSE)
                  rdata_ff[7:0] <= {map_ff[IDX_INT_CAUSE][7:4], cause_ff};
               else if (rd_idx == IDX_CAL_STAT)
                  rdata_ff[7:0] <= {5'h00, cal_st_ff != LSC_CAL_IDLE,
                                    rc_done_ff, ant_done_ff};
               else if (rd_idx == IDX_TRIM)
                  rdata_ff[7:0] <= {sys_trim_ff, tmr_trim_ff};
               else
                  rdata_ff[7:0] <= map_ff[rd_idx];
            end
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign noise_hi = noise_meas > map_ff[IDX_NOISE_WD][POS_NF_LSB +: 3];
   assign strike_ok = (strike_cnt_ff + 5'd1) >=
                      min_strikes(map_ff[IDX_STRK_SPK][POS_MINS_LSB +: 2]);

   always_comb begin
      cause_set = 4'h0;
      if (!pd) begin
         if (noise_hi && !noise_hi_ff)
            cause_set = cause_set | CAUSE_NOISE;
         if (disturber_evt && !map_ff[IDX_INT_CAUSE][POS_DIST_MASK])
            cause_set = cause_set | CAUSE_DIST;
         if (strike_evt && strike_ok)
            cause_set = cause_set | CAUSE_LIGHT;
      end
   end

   assign cause_clr = rd_fire && rd_idx == IDX_INT_CAUSE;

   // cause held until read, set beats clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cause_ff    <= 4'h0;
         noise_hi_ff <= 1'b0;
      end else if (ce) begin
         noise_hi_ff <= noise_hi && !pd;
         cause_ff    <= (cause_clr ? 4'h0 : cause_ff) | cause_set;
      end
   end

   // strikes counted inside the rolling window
   // window restarts at first strike, a cheap stand-in for sliding
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strike_cnt_ff <= 5'd0;
         strike_tmr_ff <= '0;
      end else if (ce) begin
         if (pd) begin
            strike_cnt_ff <= 5'd0;
            strike_tmr_ff <= '0;
         end else begin
            if (strike_cnt_ff != 5'd0)
               strike_tmr_ff <= strike_tmr_ff + 1'b1;
            if (strike_cnt_ff != 5'd0 &&
                strike_tmr_ff >= SW_W'(STRIKE_WIN - 1)) begin
               strike_cnt_ff <= strike_evt ? 5'd1 : 5'd0;
               strike_tmr_ff <= '0;
            end else if (strike_evt && strike_cnt_ff != 5'd16) begin
               strike_cnt_ff <= strike_cnt_ff + 5'd1;
            end
         end
      end
   end

   // calibration: four-step successive approximation per oscillator
   always_comb begin
      osc_sel_pin = antenna_lc_osc;
      meas_win    = WIN_W'(WIN_FAST);
      trial       = 4'h0;
      case (cal_st_ff)
         LSC_CAL_ANT: trial = map_ff[IDX_TUNE][POS_CAP_LSB +: 4];
         LSC_CAL_TMR: begin
            osc_sel_pin = timer_rc_osc;
            trial       = tmr_trim_ff;
         end
         LSC_CAL_SYS: begin
            osc_sel_pin = system_rc_osc;
            meas_win    = WIN_W'(WIN_SLOW);
            trial       = sys_trim_ff;
         end
         default: trial = 4'h0;
      endcase
   end

   always_comb begin
      case (cal_st_ff)
         // more capacitance lowers antenna frequency
         LSC_CAL_ANT: keep_bit = meas_cnt >= TGT_ANT;
         LSC_CAL_TMR: keep_bit = meas_cnt <= TGT_TMR;
         LSC_CAL_SYS: keep_bit = meas_cnt <= TGT_SYS;
         default:     keep_bit = 1'b0;
      endcase
   end

   assign cap_wr     = (ant_go && !pd) ||
                       (cal_st_ff == LSC_CAL_ANT && meas_done && !pd);
   assign cap_wr_val = ant_go ? 4'h8 :
                       (keep_bit ? trial : trial & ~(4'h1 << bit_ff)) |
                       (bit_ff != 2'd0 ? 4'h1 << (bit_ff - 2'd1) : 4'h0);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cal_st_ff     <= LSC_CAL_IDLE;
         bit_ff        <= 2'd3;
         meas_wait_ff  <= 1'b0;
         meas_start_ff <= 1'b0;
         ant_done_ff   <= 1'b0;
         rc_done_ff    <= 1'b0;
         tmr_trim_ff   <= 4'h8;
         sys_trim_ff   <= 4'h8;
      end else if (ce) begin
         meas_start_ff <= 1'b0;
         if (pd) begin
            cal_st_ff    <= LSC_CAL_IDLE;
            meas_wait_ff <= 1'b0;
            ant_done_ff  <= 1'b0;
            rc_done_ff   <= 1'b0;
         end else begin
            case (cal_st_ff)
               LSC_CAL_IDLE: begin
                  bit_ff <= 2'd3;
                  if (ant_go) begin
                     cal_st_ff     <= LSC_CAL_ANT;
                     ant_done_ff   <= 1'b0;
                     rc_done_ff    <= 1'b0;
                     meas_start_ff <= 1'b1;
                     meas_wait_ff  <= 1'b1;
                  // rc trim only with a tuned antenna
                  end else if (rc_go && ant_done_ff) begin
                     cal_st_ff     <= LSC_CAL_TMR;
                     rc_done_ff    <= 1'b0;
                     tmr_trim_ff   <= 4'h8;
                     sys_trim_ff   <= 4'h8;
                     meas_start_ff <= 1'b1;
                     meas_wait_ff  <= 1'b1;
                  end
               end
               LSC_CAL_ANT, LSC_CAL_TMR, LSC_CAL_SYS: begin
                  if (meas_done && meas_wait_ff) begin
                     if (cal_st_ff == LSC_CAL_TMR)
                        tmr_trim_ff <= cap_wr_val;
                     if (cal_st_ff == LSC_CAL_SYS)
                        sys_trim_ff <= cap_wr_val;
                     if (bit_ff != 2'd0) begin
                        bit_ff        <= bit_ff - 2'd1;
                        meas_start_ff <= 1'b1;
                     end else begin
                        bit_ff <= 2'd3;
                        if (cal_st_ff == LSC_CAL_ANT) begin
                           cal_st_ff    <= LSC_CAL_IDLE;
                           ant_done_ff  <= 1'b1;
                           meas_wait_ff <= 1'b0;
                        end else if (cal_st_ff == LSC_CAL_TMR) begin
                           cal_st_ff     <= LSC_CAL_SYS;
                           meas_start_ff <= 1'b1;
                        end else begin
                           cal_st_ff    <= LSC_CAL_IDLE;
                           rc_done_ff   <= 1'b1;
                           meas_wait_ff <= 1'b0;
                        end
                     end
                  end
               end
               default: cal_st_ff <= LSC_CAL_IDLE;
            endcase
         end
      end
   end

   lsc_freq_meter #(
      .CNT_W    (CNT_W),
      .WIN_W    (WIN_W)
   ) u_meter (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .osc_pin  (osc_sel_pin),
      .start    (meas_start_ff),
      .win_cyc  (meas_win),
      .edge_cnt (meas_cnt),
      .done     (meas_done)
   );

   // analog controls follow the map and the rc trim registers, also in power-down
   assign powered_down          = pd;
   assign front_end_amplifier   = map_ff[IDX_PWR_FE][POS_FE_LSB +: 5];
   assign watchdog_threshold    = map_ff[IDX_NOISE_WD][POS_WD_LSB +: 4];
   // spike rejection field, reset value 2
   assign spike_rejection_level = map_ff[IDX_STRK_SPK][POS_SPK_LSB +: 4];
   assign antenna_tune_cap      = map_ff[IDX_TUNE][POS_CAP_LSB +: 4];
   assign timer_rc_trim         = tmr_trim_ff;
   assign system_rc_trim        = sys_trim_ff;
   assign irq                   = cause_ff != 4'h0;
endmodule : lsc_ctrl

// File: verilog/lsc_pkg.sv
// lsc_pkg: register indices, field positions, reset values and timing
// figures of the lightning sensor configuration controller.
// assumes a 50 MHz system clock; byte address is four times the index.
package lsc_pkg;
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          NUM_MAP       = 11;
   // register indices
   localparam logic [3:0]  IDX_PWR_FE    = 4'h0;
   localparam logic [3:0]  IDX_NOISE_WD  = 4'h1;
   localparam logic [3:0]  IDX_STRK_SPK  = 4'h2;
   localparam logic [3:0]  IDX_INT_CAUSE = 4'h3;
   localparam logic [3:0]  IDX_TUNE      = 4'h8;
   localparam logic [3:0]  IDX_LAST_MAP  = 4'hA;
   localparam logic [3:0]  IDX_CAL_STAT  = 4'hC;
   localparam logic [3:0]  IDX_TRIM      = 4'hD;
   // field positions
   localparam int          POS_PWR_DOWN  = 0;
   localparam int          POS_FE_LSB    = 1;
   localparam int          POS_NF_LSB    = 4;
   localparam int          POS_WD_LSB    = 0;
   localparam int          POS_SPK_LSB   = 0;
   localparam int          POS_MINS_LSB  = 4;
   localparam int          POS_DIST_MASK = 5;
   localparam int          POS_ANT_START = 7;
   localparam int          POS_RC_START  = 6;
   localparam int          POS_CAP_LSB   = 0;
   // interrupt cause codes
   localparam logic [3:0]  CAUSE_NOISE   = 4'h1;
   localparam logic [3:0]  CAUSE_DIST    = 4'h4;
   localparam logic [3:0]  CAUSE_LIGHT   = 4'h8;
   // reset image of the map
   localparam logic [7:0]  RST_MAP [0:10] = '{
      8'h10, 8'h21, 8'hC2, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h3F, 8'h00, 8'hAD, 8'h00};
   // oscillator targets
   localparam longint      ANT_HZ        = 500_000;
   localparam longint      TMR_HZ        = 1_100_000;
   localparam longint      SYS_HZ        = 32_000;
   // measurement windows and strike window
   localparam longint      WIN_FAST_US   = 100;
   localparam longint      WIN_SLOW_US   = 1000;
   localparam longint      STRIKE_WIN_MIN = 15;
   localparam longint      WIN_FAST_CYC  = WIN_FAST_US * CLK_HZ / 1_000_000;
   localparam longint      WIN_SLOW_CYC  = WIN_SLOW_US * CLK_HZ / 1_000_000;
   localparam longint      STRIKE_WIN_CYC = STRIKE_WIN_MIN * 60 * CLK_HZ;
   // axi responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      LSC_CAL_IDLE,
      LSC_CAL_ANT,
      LSC_CAL_TMR,
      LSC_CAL_SYS
   } lsc_cal_t;
endpackage : lsc_pkg

// File: verilog/lsc_freq_meter.sv
// lsc_freq_meter: counts rising edges of an asynchronous oscillator pin
// over a window of system clock cycles.
// assumes the pin runs well below half the system clock.
`timescale 1ns/100ps
module lsc_freq_meter #(
   parameter int CNT_W = 16,
   parameter int WIN_W = 20
) (
   // clock, reset, enable
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ce,
   // oscillator pin
   input  wire logic             osc_pin,
   // control
   input  wire logic             start,
   input  wire logic [WIN_W-1:0] win_cyc,
   // result
   output logic      [CNT_W-1:0] edge_cnt,
   output logic                  done
);
   logic             sync1_ff;
   logic             sync2_ff;
   logic             prev_ff;
   logic             busy_ff;
   logic [WIN_W-1:0] win_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             done_ff;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else if (ce) begin
         sync1_ff <= osc_pin;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_ff <= 1'b0;
         win_ff  <= '0;
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else if (ce) begin
         done_ff <= 1'b0;
         if (start) begin
            busy_ff <= 1'b1;
            win_ff  <= win_cyc;
            cnt_ff  <= '0;
         end else if (busy_ff) begin
            if (sync2_ff && !prev_ff && cnt_ff != '1)
               cnt_ff <= cnt_ff + 1'b1;
            if (win_ff <= 1) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               win_ff <= win_ff - 1'b1;
            end
         end
      end
   end

   assign edge_cnt = cnt_ff;
   assign done     = done_ff;
endmodule : lsc_freq_meter

// File: tb/lsc_ctrl_monitor.sv
// lsc_ctrl_monitor: bus handshake and event checks at the controller ports.
// assumes ce stays high, as the bench keeps it.
`timescale 1ns/100ps
module lsc_ctrl_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // controls
   input wire logic        powered_down,
   input wire logic [3:0]  spike_rejection_level,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read ready wrong");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_pd_quiet: assert property (powered_down && !irq |=> !irq)
      else $error("interrupt in power down");
   a_irq_awake: assert property ($rose(irq) |-> !$past(powered_down))
      else $error("interrupt raised from power down");
   // map lands at the edge that raises the write answer
   a_spk_write: assert property (
      $changed(spike_rejection_level) |-> $rose(s_axi_bvalid))
      else $error("spike level changed without write");
endmodule : lsc_ctrl_monitor

bind lsc_ctrl lsc_ctrl_monitor u_mon (.*);

// File: tb/lsc_osc_model.sv
// lsc_osc_model: free-running oscillator pins seen by the frequency meter.
// assumes periods unrelated to mclk; rates are not trim dependent.
`timescale 1ns/100ps
module lsc_osc_model (
   // oscillator pins
   output logic antenna_lc_osc,
   output logic timer_rc_osc,
   output logic system_rc_osc
);
   initial begin
      antenna_lc_osc = 1'b0;
      forever #37.3 antenna_lc_osc = ~antenna_lc_osc;
   end
   initial begin
      timer_rc_osc = 1'b0;
      forever #51.7 timer_rc_osc = ~timer_rc_osc;
   end
   initial begin
      system_rc_osc = 1'b0;
      forever #83.1 system_rc_osc = ~system_rc_osc;
   end
endmodule : lsc_osc_model

// File: tb/lsc_ctrl_tb_top.sv
// lsc_ctrl_tb_top: axi4-lite master and event driver for the controller.
// assumes shortened calibration and strike windows set below.
`timescale 1ns/100ps
module lsc_ctrl_tb_top;
   import lsc_pkg::*;
   logic mclk, rst, ce, awv, wv, br, arv, rr, dev, sev;
   logic aw_r, w_r, bv, ar_r, rv, irq, pd, a_o, t_o, s_o;
   logic [7:0] awa, ara, d;
   logic [31:0] wdat, rdat;
   logic [1:0] bres, rres, r;
   logic [2:0] nm;
   logic [3:0] wdt, spk, cap, tt, st;
   logic [4:0] fe;
   int err_count, n_tests, cyc;
   lsc_ctrl #(.WIN_FAST(50), .WIN_SLOW(500), .STRIKE_WIN(1000)) uut (
      .mclk(mclk), .rst(rst), .ce(ce), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wdat),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(w_r),
      .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
      .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .noise_meas(nm), .disturber_evt(dev),
      .strike_evt(sev), .antenna_lc_osc(a_o), .timer_rc_osc(t_o),
      .system_rc_osc(s_o), .powered_down(pd), .front_end_amplifier(fe),
      .watchdog_threshold(wdt), .spike_rejection_level(spk),
      .antenna_tune_cap(cap), .timer_rc_trim(tt), .system_rc_trim(st),
      .irq(irq));
   lsc_osc_model u_osc (.antenna_lc_osc(a_o), .timer_rc_osc(t_o),
      .system_rc_osc(s_o));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] i, input logic [7:0] v);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge mclk);
      awa <= {2'b00, i, 2'b00};
      wdat <= {24'h0, v};
      {awv, wv, br} <= 3'b111;
      while (!(ta && tw)) begin
         @(negedge mclk);
         ta = ta || aw_r;
         tw = tw || w_r;
         @(posedge mclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      do @(negedge mclk); while (!bv);
      @(posedge mclk);
      br <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] i);
      @(posedge mclk);
      ara <= {2'b00, i, 2'b00};
      {arv, rr} <= 2'b11;
      do @(negedge mclk); while (!ar_r);
      @(posedge mclk);
      arv <= 1'b0;
      do @(negedge mclk); while (!rv);
      d = rdat[7:0];
      r = rres;
      @(posedge mclk);
      rr <= 1'b0;
   endtask : rd
   task automatic evt(input logic s);
      @(posedge mclk);
      {dev, sev} <= {!s, s};
      @(posedge mclk);
      {dev, sev} <= 2'b00;
      @(negedge mclk);
   endtask : evt
   task automatic t_map;
      chk("spike", 4'h2, spk);
      for (int i = 0; i < NUM_MAP; i++) begin
         rd(i[3:0]);
         chk("map", RST_MAP[i], d);
      end
      rd(4'hF);
      chk("resp", RESP_SLVERR, r);
      wr(4'h1, 8'h0B);
      chk("watchdog_threshold", 4'hB, wdt);
      wr(4'h2, 8'hC7);
      chk("spike", 4'h7, spk);
      for (int i = 4; i < NUM_MAP; i++) begin
         if (i == 8) continue;
         wr(i[3:0], ~RST_MAP[i]);
         rd(i[3:0]);
         chk("map", 8'(~RST_MAP[i]), d);
      end
      wr(4'h1, 8'h21);
   endtask : t_map
   task automatic t_events;
      evt(1'b0);
      chk("irq", 1'b1, irq);
      rd(4'h3);
      chk("cause", CAUSE_DIST, d);
      chk("irq", 1'b0, irq);
      wr(4'h3, 8'h20);
      evt(1'b0);
      chk("irq", 1'b0, irq);
      wr(4'h3, 8'h00);
      // floor 2: level 2 stays quiet, level 3 trips
      for (int v = 2; v < 4; v++) begin
         @(posedge mclk);
         nm <= v[2:0];
         @(posedge mclk);
         @(negedge mclk);
         chk("irq", v == 3, irq);
      end
      rd(4'h3);
      chk("cause", CAUSE_NOISE, d);
      nm <= 3'h0;
   endtask : t_events
   task automatic t_strikes;
      int need [4] = '{1, 5, 9, 16};
      for (int c = 0; c < 4; c++) begin
         wr(4'h0, 8'h11);
         chk("pd", 1'b1, pd);
         chk("fe", 5'h08, fe);
         evt(1'b1);
         chk("irq", 1'b0, irq);
         wr(4'h0, 8'h10);
         wr(4'h2, {2'b11, c[1:0], 4'h2});
         repeat (need[c] - 1) evt(1'b1);
         chk("irq", 1'b0, irq);
         evt(1'b1);
         chk("irq", 1'b1, irq);
         rd(4'h3);
         chk("cause", CAUSE_LIGHT, d);
      end
   endtask : t_strikes
   task automatic poll(input logic [7:0] m);
      int k;
      k = 0;
      do begin
         rd(4'hC);
         k++;
      end while ((d[2] || (d & m) == 8'h00) && k < 1000);
   endtask : poll
   task automatic t_cal;
      rd(4'hD);
      chk("trim", 8'h88, d);
      chk("trim", 8'h88, {st, tt});
      rd(4'hC);
      chk("cal", 8'h00, d);
      wr(4'h8, 8'h40);
      rd(4'hC);
      chk("cal", 8'h00, d);
      wr(4'h8, 8'h80);
      chk("cap", 4'h8, cap);
      poll(8'h01);
      chk("cal", 8'h01, d);
      wr(4'h8, 8'h40);
      poll(8'h02);
      chk("cal", 8'h03, d);
      wr(4'h0, 8'h11);
      wr(4'h0, 8'h10);
      rd(4'hC);
      chk("cal", 8'h00, d);
   endtask : t_cal
   task automatic complete_run;
      $display("mismatches %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      {ce, rst} = 2'b11;
      {awv, wv, br, arv, rr, dev, sev} = '0;
      {awa, ara, wdat, nm} = '0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_map();
      t_events();
      t_strikes();
      t_cal();
      complete_run();
   end
endmodule : lsc_ctrl_tb_top
